// ---- logic/power_protect_pkg.sv ----
// Constants, layouts and types shared by the channel power and protection logic
`default_nettype none
package power_protect_pkg;

  // Register port shape
  localparam int unsigned ADDR_W = 3;  // Register select width
  localparam int unsigned DATA_W = 16; // Register data width
  localparam int unsigned NUM_CH = 2;  // Channels A and B

  // Register select codes
  localparam logic [2:0] SEL_POWER_CTRL = 3'h2; // Power control register
  localparam logic [2:0] SEL_CONTROL    = 3'h3; // Control register
  localparam logic [2:0] SEL_IRQ_STATUS = 3'h4; // Sticky event status, write one to clear
  localparam logic [2:0] SEL_IRQ_MASK   = 3'h5; // Interrupt mask, same layout

  // Power control register field positions
  localparam int unsigned PC_OC_B_BIT  = 9; // Channel B overcurrent flag
  localparam int unsigned PC_OC_A_BIT  = 7; // Channel A overcurrent flag
  localparam int unsigned PC_ALERT_BIT = 5; // Thermal alert flag
  localparam int unsigned PC_PU_B_BIT  = 2; // Channel B power-on
  localparam int unsigned PC_PU_A_BIT  = 0; // Channel A power-on

  // Control register field positions
  localparam int unsigned CR_TSD_EN_BIT = 3; // Thermal protect enable
  localparam int unsigned CR_CLAMP_BIT  = 2; // Current clamp enable
  localparam int unsigned CR_CLR_BIT    = 1; // Clear-level select
  localparam int unsigned CR_SDO_BIT    = 0; // Serial readback disable

  // Interrupt status field positions
  localparam int unsigned IRQ_OC_A_BIT  = 0; // Channel A overcurrent event
  localparam int unsigned IRQ_OC_B_BIT  = 1; // Channel B overcurrent event
  localparam int unsigned IRQ_ALERT_BIT = 2; // Thermal event
  localparam int unsigned IRQ_W         = 3; // Status and mask width

  // Reset values
  localparam logic            RST_TSD_EN = 1'b0; // Thermal protection off
  localparam logic            RST_CLAMP  = 1'b1; // Current clamp on
  localparam logic            RST_CLR    = 1'b0; // Clear to zero
  localparam logic            RST_SDO    = 1'b0; // Readback enabled
  localparam logic [1:0]      RST_PU     = 2'h0; // Both channels powered down
  localparam logic [IRQ_W-1:0] RST_MASK  = 3'h0; // All events masked

  // Synchroniser depth for analog detector inputs
  localparam int unsigned SYNC_STAGES = 2;

  // Per-channel output stage state
  typedef enum logic [1:0] {
    CH_HOLD  = 2'b00, // Supplies or word not ready, output grounded
    CH_OFF   = 2'b01, // Powered down by software or thermal event
    CH_ON    = 2'b10, // Amplifier drives the pin
    CH_FAULT = 2'b11  // Powered down by overcurrent, waits for power-on write
  } ch_state_t;

  // Switch controls for one channel output stage
  typedef struct packed {
    logic amp_output_gate;     // Amplifier connected to channel_output_pin
    logic ground_clamp_switch; // Pin tied to ground through clamp resistance
    logic current_limit_en;    // Constant current limit armed
  } chan_ctrl_t;

endpackage
`default_nettype wire

// ---- logic/pin_sync.sv ----
// Two-flop synchroniser for a group of asynchronous detector levels
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
  parameter int unsigned WIDTH = 3
) (
  input  wire logic             sys_clk_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] async_i,
  output var  logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_q; // First stage, read only by the second

  // Both stages reset to idle so no false fault after reset
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_q <= '0;
      sync_o <= '0;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end

endmodule
`default_nettype wire

// ---- logic/channel_power_protection.sv ----
// Channel power sequencing, overcurrent and thermal protection with register port
`timescale 1ns/1ns
`default_nettype none
module channel_power_protection (
  input  wire logic                                   sys_clk_i,
  input  wire logic                                   rst_i,
  // Register port
  input  wire logic [power_protect_pkg::ADDR_W-1:0]   reg_addr_i,
  input  wire logic [power_protect_pkg::DATA_W-1:0]   reg_wdata_i,
  input  wire logic                                   reg_write_i,
  input  wire logic                                   reg_read_i,
  output var  logic [power_protect_pkg::DATA_W-1:0]   reg_rdata_o,
  // Power-up conditions
  input  wire logic                                   supply_stable_i,
  input  wire logic [power_protect_pkg::NUM_CH-1:0]   dac_word_load_i,
  // Analog detectors, asynchronous
  input  wire logic [power_protect_pkg::NUM_CH-1:0]   overcurrent_det_i,
  input  wire logic                                   overtemp_det_i,
  // Output stage controls, index 0 is channel A
  output var  power_protect_pkg::chan_ctrl_t [1:0]    chan_ctrl_o,
  output var  logic                                   clr_select_o,
  output var  logic                                   sdo_disable_o,
  output var  logic                                   irq_o
);

  // True when a state connects the amplifier to the pin
  function automatic logic is_driving(input power_protect_pkg::ch_state_t st);
    is_driving = (st == power_protect_pkg::CH_ON);
  endfunction

  // Synchronised detector levels
  logic [1:0] oc_sync;     // Per-channel overcurrent
  logic       ot_sync;     // Overtemperature
  logic [2:0] det_sync;    // Bundle from synchroniser

  // Configuration bits
  logic thermal_protect_enable_q; // Thermal shutdown armed
  logic clamp_enable_q;           // Current clamp versus auto power-down
  logic clr_select_q;             // Clear-level select
  logic sdo_disable_q;            // Readback disable

  // Status and power bits
  logic [1:0] channel_power_on_q; // Software power-on bits
  logic [1:0] overcurrent_flag_q; // Read-only overcurrent flags
  logic [1:0] overcurrent_flag_d; // Next overcurrent flags
  logic       thermal_alert_flag_q; // Read-only thermal alert
  logic [1:0] word_valid_q;         // A valid word reached the channel

  // Interrupt registers
  logic [power_protect_pkg::IRQ_W-1:0] irq_status_q; // Sticky events
  logic [power_protect_pkg::IRQ_W-1:0] irq_mask_q;   // Enables
  logic [power_protect_pkg::IRQ_W-1:0] irq_event;    // One-cycle events

  // Channel state
  power_protect_pkg::ch_state_t [1:0] st_q; // Current state per channel
  power_protect_pkg::ch_state_t [1:0] st_d; // Next state per channel
  logic [1:0] fault_trip;  // Auto power-down fires this cycle
  logic [1:0] pu_set_wr;   // Software writes a one to a power-on bit
  logic       thermal_trip; // Thermal shutdown fires

  // Register decode strobes
  logic wr_power;   // Write to power control
  logic wr_control; // Write to control
  logic wr_status;  // Write to interrupt status
  logic wr_mask;    // Write to interrupt mask

  // Detector inputs pass two flops before any flag sees them
  pin_sync #(
    .WIDTH (3)
  ) u_det_sync (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .async_i   ({overtemp_det_i, overcurrent_det_i}),
    .sync_o    (det_sync)
  );

  assign oc_sync = det_sync[1:0];
  assign ot_sync = det_sync[2];

  // Address decode of write strobes
  assign wr_power   = reg_write_i && (reg_addr_i == power_protect_pkg::SEL_POWER_CTRL);
  assign wr_control = reg_write_i && (reg_addr_i == power_protect_pkg::SEL_CONTROL);
  assign wr_status  = reg_write_i && (reg_addr_i == power_protect_pkg::SEL_IRQ_STATUS);
  assign wr_mask    = reg_write_i && (reg_addr_i == power_protect_pkg::SEL_IRQ_MASK);

  assign pu_set_wr[0] = wr_power && reg_wdata_i[power_protect_pkg::PC_PU_A_BIT];
  assign pu_set_wr[1] = wr_power && reg_wdata_i[power_protect_pkg::PC_PU_B_BIT];

  // Shutdown only counts once software armed it
  assign thermal_trip = thermal_protect_enable_q && ot_sync;

  // Control register, clamp comes up enabled
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      thermal_protect_enable_q <= power_protect_pkg::RST_TSD_EN;
      clamp_enable_q           <= power_protect_pkg::RST_CLAMP;
      clr_select_q             <= power_protect_pkg::RST_CLR;
      sdo_disable_q            <= power_protect_pkg::RST_SDO;
    end else if (wr_control) begin
      thermal_protect_enable_q <= reg_wdata_i[power_protect_pkg::CR_TSD_EN_BIT];
      clamp_enable_q           <= reg_wdata_i[power_protect_pkg::CR_CLAMP_BIT];
      clr_select_q             <= reg_wdata_i[power_protect_pkg::CR_CLR_BIT];
      sdo_disable_q            <= reg_wdata_i[power_protect_pkg::CR_SDO_BIT];
    end
  end

  assign clr_select_o  = clr_select_q;
  assign sdo_disable_o = sdo_disable_q;

  // Thermal alert is not writable; it clears only once cool and power is rewritten
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      thermal_alert_flag_q <= 1'b0;
    end else if (thermal_trip) begin
      thermal_alert_flag_q <= 1'b1;
    end else if (wr_power && !ot_sync) begin
      thermal_alert_flag_q <= 1'b0;
    end
  end

  generate
    for (genvar c = 0; c < 2; c++) begin : g_ch
      // Valid word latch; a brownout forgets it so power-up clamping repeats
      always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
          word_valid_q[c] <= 1'b0;
        end else if (!supply_stable_i) begin
          word_valid_q[c] <= 1'b0;
        end else if (dac_word_load_i[c]) begin
          word_valid_q[c] <= 1'b1;
        end
      end

      // Auto power-down fires only from a driving channel with clamp off
      assign fault_trip[c] = (st_q[c] == power_protect_pkg::CH_ON) && supply_stable_i &&
                             word_valid_q[c] && !thermal_trip && !clamp_enable_q &&
                             oc_sync[c];

      // Next state of the output stage
      always_comb begin
        st_d[c] = st_q[c];
        if (!supply_stable_i || !word_valid_q[c]) begin
          st_d[c] = power_protect_pkg::CH_HOLD;
        end else begin
          unique case (st_q[c])
            power_protect_pkg::CH_HOLD,
            power_protect_pkg::CH_OFF: begin
              // Release only with power-on set and no thermal event
              st_d[c] = (channel_power_on_q[c] && !thermal_trip) ?
                        power_protect_pkg::CH_ON : power_protect_pkg::CH_OFF;
            end
            power_protect_pkg::CH_ON: begin
              if (thermal_trip) begin
                st_d[c] = power_protect_pkg::CH_OFF;
              end else if (fault_trip[c]) begin
                st_d[c] = power_protect_pkg::CH_FAULT;
              end else if (!channel_power_on_q[c]) begin
                st_d[c] = power_protect_pkg::CH_OFF;
              end else begin
                st_d[c] = power_protect_pkg::CH_ON;
              end
            end
            power_protect_pkg::CH_FAULT: begin
              // Stays down until software writes power-on again
              if (thermal_trip) begin
                st_d[c] = power_protect_pkg::CH_OFF;
              end else if (pu_set_wr[c]) begin
                st_d[c] = power_protect_pkg::CH_ON;
              end else begin
                st_d[c] = power_protect_pkg::CH_FAULT;
              end
            end
          endcase
        end
      end

      // State register
      always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
          st_q[c] <= power_protect_pkg::CH_HOLD;
        end else begin
          st_q[c] <= st_d[c];
        end
      end

      // Power-on bit; hardware shutdown beats a same-cycle software write
      always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
          channel_power_on_q[c] <= power_protect_pkg::RST_PU[c];
        end else if (thermal_trip || fault_trip[c]) begin
          channel_power_on_q[c] <= 1'b0;
        end else if (wr_power) begin
          channel_power_on_q[c] <= (c == 0) ? reg_wdata_i[power_protect_pkg::PC_PU_A_BIT] :
                                              reg_wdata_i[power_protect_pkg::PC_PU_B_BIT];
        end
      end

      // Flag is sticky in fault, else tracks the short while limiting
      assign overcurrent_flag_d[c] = (st_d[c] == power_protect_pkg::CH_FAULT) ||
                                     (clamp_enable_q && is_driving(st_d[c]) &&
                                      oc_sync[c]);

      always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
          overcurrent_flag_q[c] <= 1'b0;
        end else begin
          overcurrent_flag_q[c] <= overcurrent_flag_d[c];
        end
      end

      // Switch drive registered from next state so it lines up with st_q
      always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
          chan_ctrl_o[c] <= '{amp_output_gate: 1'b0, ground_clamp_switch: 1'b1,
                              current_limit_en: 1'b0};
        end else begin
          chan_ctrl_o[c].amp_output_gate     <= is_driving(st_d[c]);
          chan_ctrl_o[c].ground_clamp_switch <= !is_driving(st_d[c]);
          chan_ctrl_o[c].current_limit_en    <= clamp_enable_q && is_driving(st_d[c]);
        end
      end
    end
  endgenerate

  // Events are rising edges of the flags
  assign irq_event[power_protect_pkg::IRQ_OC_A_BIT]  = overcurrent_flag_d[0] &&
                                                       !overcurrent_flag_q[0];
  assign irq_event[power_protect_pkg::IRQ_OC_B_BIT]  = overcurrent_flag_d[1] &&
                                                       !overcurrent_flag_q[1];
  assign irq_event[power_protect_pkg::IRQ_ALERT_BIT] = thermal_trip && !thermal_alert_flag_q;

  // Sticky status, write one clears, a new event wins over the clear
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_status_q <= '0;
    end else if (wr_status) begin
      irq_status_q <= (irq_status_q & ~reg_wdata_i[power_protect_pkg::IRQ_W-1:0]) | irq_event;
    end else begin
      irq_status_q <= irq_status_q | irq_event;
    end
  end

  // Mask register
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_mask_q <= power_protect_pkg::RST_MASK;
    end else if (wr_mask) begin
      irq_mask_q <= reg_wdata_i[power_protect_pkg::IRQ_W-1:0];
    end
  end

  assign irq_o = |(irq_status_q & irq_mask_q);

  // Read data valid only in the cycle after the strobe; unmapped reads give zero
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= '0;
    end else begin
      reg_rdata_o <= '0;
      if (reg_read_i) begin
        unique case (reg_addr_i)
          power_protect_pkg::SEL_POWER_CTRL: begin
            reg_rdata_o[power_protect_pkg::PC_OC_B_BIT]  <= overcurrent_flag_q[1];
            reg_rdata_o[power_protect_pkg::PC_OC_A_BIT]  <= overcurrent_flag_q[0];
            reg_rdata_o[power_protect_pkg::PC_ALERT_BIT] <= thermal_alert_flag_q;
            reg_rdata_o[power_protect_pkg::PC_PU_B_BIT]  <= channel_power_on_q[1];
            reg_rdata_o[power_protect_pkg::PC_PU_A_BIT]  <= channel_power_on_q[0];
          end
          power_protect_pkg::SEL_CONTROL: begin
            reg_rdata_o[power_protect_pkg::CR_TSD_EN_BIT] <= thermal_protect_enable_q;
            reg_rdata_o[power_protect_pkg::CR_CLAMP_BIT]  <= clamp_enable_q;
            reg_rdata_o[power_protect_pkg::CR_CLR_BIT]    <= clr_select_q;
            reg_rdata_o[power_protect_pkg::CR_SDO_BIT]    <= sdo_disable_q;
          end
          power_protect_pkg::SEL_IRQ_STATUS: begin
            reg_rdata_o[power_protect_pkg::IRQ_W-1:0] <= irq_status_q;
          end
          power_protect_pkg::SEL_IRQ_MASK: begin
            reg_rdata_o[power_protect_pkg::IRQ_W-1:0] <= irq_mask_q;
          end
          default: begin
            reg_rdata_o <= '0;
          end
        endcase
      end
    end
  end

  // Checks on the protection behaviour
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  reset_state_a: assert property ($fell(rst_i) |-> channel_power_on_q == 2'h0)
    else $error("channel not powered down after reset");
  clamp_default_a: assert property ($fell(rst_i) |-> clamp_enable_q &&
                                    !thermal_protect_enable_q)
    else $error("clamp or thermal enable wrong after reset");
  hold_grounded_a: assert property (!supply_stable_i |=>
                                    chan_ctrl_o[0].ground_clamp_switch &&
                                    !chan_ctrl_o[0].amp_output_gate &&
                                    chan_ctrl_o[1].ground_clamp_switch)
    else $error("output not grounded while supplies unstable");
  off_grounded_a: assert property (st_q[1] != power_protect_pkg::CH_ON |->
                                   chan_ctrl_o[1].ground_clamp_switch &&
                                   !chan_ctrl_o[1].amp_output_gate)
    else $error("powered-down channel still driven");
  clamp_flag_a: assert property (st_q[0] == power_protect_pkg::CH_ON &&
                                 clamp_enable_q && oc_sync[0] && channel_power_on_q[0] &&
                                 supply_stable_i && !thermal_trip |=>
                                 overcurrent_flag_q[0] && st_q[0] == power_protect_pkg::CH_ON)
    else $error("clamp mode short not flagged or channel dropped");
  auto_down_a: assert property (fault_trip[1] |=>
                                st_q[1] == power_protect_pkg::CH_FAULT &&
                                !channel_power_on_q[1] && overcurrent_flag_q[1] &&
                                !chan_ctrl_o[1].amp_output_gate)
    else $error("auto power-down did not take effect");
  fault_waits_a: assert property (st_q[1] == power_protect_pkg::CH_FAULT &&
                                  !pu_set_wr[1] |=> st_q[1] != power_protect_pkg::CH_ON)
    else $error("faulted channel restarted without power-on write");
  thermal_idle_a: assert property (!thermal_protect_enable_q && !thermal_alert_flag_q |=>
                                   !thermal_alert_flag_q)
    else $error("thermal alert set while protection disabled");
  thermal_trip_a: assert property (thermal_trip |=> thermal_alert_flag_q &&
                                   channel_power_on_q == 2'h0 &&
                                   st_q[0] != power_protect_pkg::CH_ON &&
                                   st_q[1] != power_protect_pkg::CH_ON)
    else $error("overtemperature did not shut down both channels");
  power_read_a: assert property (reg_read_i &&
                                 reg_addr_i == power_protect_pkg::SEL_POWER_CTRL |=>
                                 reg_rdata_o == {6'h00, $past(overcurrent_flag_q[1]), 1'b0,
                                                 $past(overcurrent_flag_q[0]), 1'b0,
                                                 $past(thermal_alert_flag_q), 2'h0,
                                                 $past(channel_power_on_q[1]), 1'b0,
                                                 $past(channel_power_on_q[0])})
    else $error("power control readback layout wrong");
  det_sync_a: assert property (overcurrent_det_i[1] [*3] |-> oc_sync[1])
    else $error("overcurrent detector not synchronised in two cycles");

  auto_down_c: cover property (fault_trip[1] ##[1:50] pu_set_wr[1]);
  thermal_c: cover property (thermal_trip ##1 thermal_alert_flag_q);
  clamp_limit_c: cover property (overcurrent_flag_q[0] && clamp_enable_q ##[1:50]
                                 !overcurrent_flag_q[0]);
  irq_c: cover property ($rose(irq_o));

endmodule
`default_nettype wire

// ---- dv/tb_channel_power_protection.sv ----
// Self-checking bench for the channel power and protection block
`timescale 1ns/1ns
`default_nettype none
module tb_channel_power_protection;
  logic                                sys_clk = 1'b0; // 100 MHz
  logic                                rst     = 1'b1; // Async reset
  logic [2:0]                          addr    = 3'h0; // Register select
  logic [15:0]                         wdata   = 16'h0000;
  logic                                wr_s    = 1'b0; // Write strobe
  logic                                rd_s    = 1'b0; // Read strobe
  logic                                supply  = 1'b1; // Supplies good
  logic [1:0]                          word_ld = 2'h0; // Word loaded pulses
  logic [1:0]                          oc_det  = 2'h0; // Short detectors
  logic                                hot     = 1'b0; // Overtemp detector
  logic [15:0]                         rdata;
  power_protect_pkg::chan_ctrl_t [1:0] cc;             // Output stage controls
  logic                                irq;
  logic                                clr_sel;        // Clear-level select pin
  logic                                sdo_dis;        // Readback disable pin
  int                                  errors  = 0;
  int                                  checked = 0;

  // Free-running clock
  always #5 sys_clk = ~sys_clk;

  channel_power_protection u_dut (
    .sys_clk_i(sys_clk), .rst_i(rst), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_write_i(wr_s), .reg_read_i(rd_s), .reg_rdata_o(rdata),
    .supply_stable_i(supply), .dac_word_load_i(word_ld),
    .overcurrent_det_i(oc_det), .overtemp_det_i(hot), .chan_ctrl_o(cc),
    .clr_select_o(clr_sel), .sdo_disable_o(sdo_dis), .irq_o(irq)
  );

  // Compare and count
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // One-cycle write strobe
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    wr_s <= 1'b1; addr <= a; wdata <= d;
    @(posedge sys_clk);
    wr_s <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, input logic [15:0] e);
    @(posedge sys_clk);
    rd_s <= 1'b1; addr <= a;
    @(posedge sys_clk);
    rd_s <= 1'b0;
    #1 chk("rdata", e, rdata);
    @(posedge sys_clk);
  endtask

  // Outputs are looked at once settled, then the bench is back on an edge
  task automatic see(input string n, input logic [15:0] e);
    #1;
    if (n == "cc")
      chk(n, e, {10'h000, cc});
    else if (n == "irq")
      chk(n, e, {15'h0000, irq});
    else
      chk(n, e, {14'h0000, clr_sel, sdo_dis});
    @(posedge sys_clk);
  endtask

  // Reset state: both channels down and grounded, clamp on, thermal off
  task automatic t_reset;
    rd(3'h3, 16'h0004);
    rd(3'h2, 16'h0000);
    see("cc", 16'h0012);
    rd(3'h6, 16'h0000); // Unmapped reads zero
  endtask

  // Power-on bits alone do not release the clamp without a loaded word
  task automatic t_powerup;
    wr(3'h2, 16'h0005);
    cyc(4);
    see("cc", 16'h0012);
    word_ld <= 2'h3;
    cyc(1);
    word_ld <= 2'h0;
    cyc(4);
    see("cc", 16'h002D);
    wr(3'h2, 16'h0001);
    cyc(2);
    see("cc", 16'h0015);
    wr(3'h2, 16'h0005);
    cyc(2);
  endtask

  // Clamp mode: flag follows the short, channel stays on, event masked
  task automatic t_clamp;
    oc_det <= 2'h1;
    cyc(6);
    rd(3'h2, 16'h0085);
    see("irq", 16'h0000);
    oc_det <= 2'h0;
    cyc(6);
    rd(3'h2, 16'h0005);
    rd(3'h4, 16'h0001);
    wr(3'h4, 16'h0001);
    rd(3'h4, 16'h0000);
  endtask

  // Auto power-down of B, unmasked interrupt, restore by power-on write
  task automatic t_auto;
    wr(3'h3, 16'h0000);
    wr(3'h5, 16'h0002);
    oc_det <= 2'h2;
    cyc(6);
    rd(3'h2, 16'h0201);
    see("cc", 16'h0014);
    see("irq", 16'h0001);
    oc_det <= 2'h0;
    cyc(6);
    rd(3'h2, 16'h0201);
    wr(3'h4, 16'h0002);
    cyc(1);
    see("irq", 16'h0000);
    wr(3'h2, 16'h0005);
    cyc(2);
    rd(3'h2, 16'h0005);
    see("cc", 16'h0024);
  endtask

  // Supply drop grounds both outputs and forgets the words until reloaded
  task automatic t_brownout;
    wr(3'h2, 16'h0005);
    cyc(2);
    see("cc", 16'h0024);
    supply <= 1'b0;
    cyc(2);
    see("cc", 16'h0012);
    supply <= 1'b1;
    cyc(4);
    see("cc", 16'h0012);
    rd(3'h2, 16'h0005);
    word_ld <= 2'h1;
    cyc(1);
    word_ld <= 2'h0;
    cyc(3);
    see("cc", 16'h0014);
    wr(3'h3, 16'h0003);
    see("pins", 16'h0003);
  endtask

  // Heat ignored until enabled, then both down with a read-only alert
  task automatic t_thermal;
    hot <= 1'b1;
    cyc(6);
    rd(3'h2, 16'h0005);
    wr(3'h3, 16'h0008);
    cyc(6);
    rd(3'h2, 16'h0020);
    see("cc", 16'h0012);
    wr(3'h2, 16'h0025);
    rd(3'h2, 16'h0020);
    hot <= 1'b0;
    cyc(6);
    wr(3'h2, 16'h0000);
    rd(3'h2, 16'h0000);
  endtask

  // Single end of run
  task automatic print_verdict;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset();
    t_powerup();
    t_clamp();
    t_auto();
    t_thermal();
    t_brownout();
    print_verdict();
  end

  // Watchdog, far beyond the 172 cycles needed
  initial begin
    #100000;
    errors++;
    print_verdict();
  end
endmodule
`default_nettype wire
